// File: src/hsdc_consts.svh
`ifndef HSDC_CONSTS_SVH
`define HSDC_CONSTS_SVH

// register offsets
`define HSDC_OFS_TUNE 8'h0A
`define HSDC_OFS_LANG_LO 8'h20
`define HSDC_OFS_LANG_HI 8'h21
`define HSDC_OFS_SER_LEN 8'h22
`define HSDC_OFS_MAK_LEN 8'h23
// string byte arrays
`define HSDC_OFS_SER_FIRST 8'h30
`define HSDC_OFS_SER_LAST 8'h4F
`define HSDC_OFS_MAK_FIRST 8'h50
`define HSDC_OFS_MAK_LAST 8'h8F

// writable bits of the tuning register (4:2 and 1)
`define HSDC_TUNE_WR_MASK 8'h1E
// field widths of the length registers
`define HSDC_SER_LEN_W 6
`define HSDC_MAK_LEN_W 7

// reset values
`define HSDC_TUNE_RST 8'h02
`define HSDC_LANG_LO_RST 8'h09
`define HSDC_LANG_HI_RST 8'h04
`define HSDC_SER_LEN_RST 6'h14
`define HSDC_MAK_LEN_RST 7'h00

// largest string lengths in bytes
`define HSDC_SER_MAX 32
`define HSDC_MAK_MAX 64

// string descriptor fields
`define HSDC_DESC_TYPE_STRING 8'h03
`define HSDC_DESC_HEAD_LEN 7'h02
`define HSDC_LANG_BYTES 7'h02
`define HSDC_IDX_LANG 8'h00
`define HSDC_IDX_SERIAL 8'h01
`define HSDC_IDX_MAKER 8'h03

`endif

// File: src/hsdc_pkg.sv
package hsdc_pkg;

    // one byte of register or string data
    typedef logic [7:0] hsdc_byte_t;

    // string descriptor reply sequencer
    typedef enum logic [3:0] {
        HSDC_IDLE      = 4'b0001,
        HSDC_HEAD_LEN  = 4'b0010,
        HSDC_HEAD_TYPE = 4'b0100,
        HSDC_BODY      = 4'b1000
    } hsdc_state_e;

endpackage : hsdc_pkg

// File: src/hsdc_text_mem.sv
`timescale 1ns/100ps

// string byte store: one write port, two registered read ports
module hsdc_text_mem
    import hsdc_pkg::*;
#(
    parameter int DEPTH = 96,
    parameter int AW = 7
)
(
    input wire logic ref_clk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire hsdc_byte_t wdata_i,
    input wire logic re_a_i,
    input wire logic [AW-1:0] raddr_a_i,
    output hsdc_byte_t rdata_a_o,
    input wire logic re_b_i,
    input wire logic [AW-1:0] raddr_b_i,
    output hsdc_byte_t rdata_b_o
);

    hsdc_byte_t mem_ff [DEPTH]; // storage, contents undefined until loaded
    hsdc_byte_t rd_a_ff; // register read port
    hsdc_byte_t rd_b_ff; // descriptor read port

    // out-of-range reads return zero instead of unknown data
    function automatic hsdc_byte_t fetch(input logic [AW-1:0] a);
        fetch = (int'(a) < DEPTH) ? mem_ff[a] : 8'h00;
    endfunction : fetch

    // write port, frozen while ce_i is low
    always_ff @(posedge ref_clk_i)
    begin
        if (ce_i && we_i && (int'(waddr_i) < DEPTH))
        begin
            mem_ff[waddr_i] <= wdata_i;
        end
    end

    // read ports, data held between reads
    always_ff @(posedge ref_clk_i)
    begin
        if (ce_i && re_a_i)
        begin
            rd_a_ff <= fetch(raddr_a_i);
        end
        if (ce_i && re_b_i)
        begin
            rd_b_ff <= fetch(raddr_b_i);
        end
    end

    assign rdata_a_o = rd_a_ff;
    assign rdata_b_o = rd_b_ff;

endmodule : hsdc_text_mem

// File: src/hsdc_string_regs.sv
`timescale 1ns/100ps
`include "hsdc_consts.svh"

// Functional notes
// - reserved read-only bits always read zero
// - i2c mode loads tuning bits from eeprom
// - smbus mode host writes tuning bits
// - language low byte, reset 09h, index 0
// - language high byte, reset 04h, index 0
// - index 0 reports exactly one language
// - language bytes writable only with custom enable
// - serial length resets to 14h
// - serial length bits 5:0, max 32
// - nonzero serial length returns bytes, index 1
// - serial length replaceable by eeprom or host
// - maker length resets zero, zero means none
// - maker length bits 6:0, max 64
// - nonzero maker length returns bytes, index 3
// - serial bytes live at 30h to 4Fh
// - maker bytes live at 50h to 8Fh
module hsdc_string_regs
    import hsdc_pkg::*;
#(
    parameter int SER_DEPTH = `HSDC_SER_MAX,
    parameter int MAK_DEPTH = `HSDC_MAK_MAX
)
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic smbus_mode_i,
    input wire logic custom_text_enable_i,
    input wire logic ee_wr_i,
    input wire logic smb_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire hsdc_byte_t cfg_wdata_i,
    output hsdc_byte_t cfg_rdata_o,
    output hsdc_byte_t tune_cfg_o,
    input wire logic desc_req_i,
    input wire logic [7:0] desc_index_i,
    input wire logic desc_ready_i,
    output logic desc_valid_o,
    output hsdc_byte_t desc_data_o,
    output logic desc_last_o,
    output logic desc_stall_o,
    output logic desc_busy_o
);

    localparam int AW = 7; // string store address width
    hsdc_byte_t tune_ff, nxt_tune; // tuning register, writable bits only
    hsdc_byte_t lang_code_low_byte_ff, nxt_lang_code_low_byte; // language code low byte
    hsdc_byte_t lang_code_high_byte_ff, nxt_lang_code_high_byte; // language code high byte
    logic [`HSDC_SER_LEN_W-1:0] serial_text_length_ff, nxt_serial_text_length; // serial length
    logic [`HSDC_MAK_LEN_W-1:0] maker_text_length_ff, nxt_maker_text_length; // maker length
    hsdc_byte_t rd_reg_ff, nxt_rd_reg; // captured register read value
    logic rd_mem_ff, nxt_rd_mem; // last read targeted the string store

    hsdc_state_e state_ff, nxt_state; // reply sequencer
    logic [AW-1:0] cnt_ff, nxt_cnt; // next body byte to present
    logic [AW-1:0] len_ff, nxt_len; // body length of this reply
    logic [AW-1:0] base_ff, nxt_base; // store address of body byte 0
    logic is_lang_ff, nxt_is_lang; // body comes from the language bytes
    hsdc_byte_t data_ff, nxt_data; // byte on the reply port
    logic stall_ff, nxt_stall; // one-cycle refusal pulse
    logic wr_ok; // write accepted in the current mode
    logic mem_we; // write lands in the string store
    hsdc_byte_t mem_rd_a; // store byte for register reads
    hsdc_byte_t mem_rd_b; // store byte for replies
    hsdc_byte_t body_byte; // next body byte to present

    // address decode shared by writes and reads
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // limit a programmed length to what the array holds
    function automatic logic [AW-1:0] clamp(input logic [AW-1:0] l, input int max);
        clamp = (int'(l) > max) ? AW'(max) : l;
    endfunction : clamp

    // register read image, reserved and unmapped bits as zero
    function automatic hsdc_byte_t reg_image(input logic [7:0] a);
        case (a)
            `HSDC_OFS_TUNE: reg_image = tune_ff & `HSDC_TUNE_WR_MASK;
            `HSDC_OFS_LANG_LO: reg_image = lang_code_low_byte_ff;
            `HSDC_OFS_LANG_HI: reg_image = lang_code_high_byte_ff;
            `HSDC_OFS_SER_LEN: reg_image = {2'b00, serial_text_length_ff};
            `HSDC_OFS_MAK_LEN: reg_image = {1'b0, maker_text_length_ff};
            default: reg_image = 8'h00;
        endcase
    endfunction : reg_image

    // eeprom loads only in i2c mode, host writes only in smbus mode
    assign wr_ok = ce_i & ((ee_wr_i & ~smbus_mode_i) | (smb_wr_i & smbus_mode_i));
    assign mem_we = wr_ok & in_range(cfg_addr_i, `HSDC_OFS_SER_FIRST, `HSDC_OFS_MAK_LAST);

    // string bytes: serial first, maker right behind it
    hsdc_text_mem #(
        .DEPTH(SER_DEPTH + MAK_DEPTH),
        .AW(AW)
    ) i_hsdc_text_mem (
        .ref_clk_i(ref_clk_i),
        .ce_i(ce_i),
        .we_i(mem_we),
        .waddr_i(AW'(cfg_addr_i - `HSDC_OFS_SER_FIRST)),
        .wdata_i(cfg_wdata_i),
        .re_a_i(cfg_rd_i),
        .raddr_a_i(AW'(cfg_addr_i - `HSDC_OFS_SER_FIRST)),
        .rdata_a_o(mem_rd_a),
        .re_b_i(1'b1),
        .raddr_b_i(AW'(nxt_base + nxt_cnt)),
        .rdata_b_o(mem_rd_b)
    );

    // next register values from eeprom load or host write, plus read capture
    always_comb
    begin
        nxt_tune = tune_ff;
        nxt_lang_code_low_byte = lang_code_low_byte_ff;
        nxt_lang_code_high_byte = lang_code_high_byte_ff;
        nxt_serial_text_length = serial_text_length_ff;
        nxt_maker_text_length = maker_text_length_ff;
        nxt_rd_reg = rd_reg_ff;
        nxt_rd_mem = rd_mem_ff;
        if (wr_ok)
        begin
            case (cfg_addr_i)
                // only bits 4:2 and 1 take the new value
                `HSDC_OFS_TUNE: nxt_tune = cfg_wdata_i & `HSDC_TUNE_WR_MASK;
                `HSDC_OFS_LANG_LO:
                    if (custom_text_enable_i)
                        nxt_lang_code_low_byte = cfg_wdata_i;
                `HSDC_OFS_LANG_HI:
                    if (custom_text_enable_i)
                        nxt_lang_code_high_byte = cfg_wdata_i;
                // upper reserved bits dropped
                `HSDC_OFS_SER_LEN:
                    nxt_serial_text_length = cfg_wdata_i[`HSDC_SER_LEN_W-1:0];
                `HSDC_OFS_MAK_LEN:
                    nxt_maker_text_length = cfg_wdata_i[`HSDC_MAK_LEN_W-1:0];
                default: ; // arrays go to the store
            endcase
        end
        // a read in a write cycle sees the old value, held until the next read
        if (cfg_rd_i)
        begin
            nxt_rd_reg = reg_image(cfg_addr_i);
            nxt_rd_mem = in_range(cfg_addr_i, `HSDC_OFS_SER_FIRST, `HSDC_OFS_MAK_LAST);
        end
    end

    // configuration and read registers
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tune_ff <= `HSDC_TUNE_RST;
            lang_code_low_byte_ff <= `HSDC_LANG_LO_RST;
            lang_code_high_byte_ff <= `HSDC_LANG_HI_RST;
            serial_text_length_ff <= `HSDC_SER_LEN_RST;
            maker_text_length_ff <= `HSDC_MAK_LEN_RST;
            rd_reg_ff <= 8'h00;
            rd_mem_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            tune_ff <= nxt_tune;
            lang_code_low_byte_ff <= nxt_lang_code_low_byte;
            lang_code_high_byte_ff <= nxt_lang_code_high_byte;
            serial_text_length_ff <= nxt_serial_text_length;
            maker_text_length_ff <= nxt_maker_text_length;
            rd_reg_ff <= nxt_rd_reg;
            rd_mem_ff <= nxt_rd_mem;
        end
    end

    assign cfg_rdata_o = rd_mem_ff ? mem_rd_a : rd_reg_ff;
    assign tune_cfg_o = tune_ff & `HSDC_TUNE_WR_MASK;

    // body byte: language pair or store output
    assign body_byte = is_lang_ff ?
        ((cnt_ff == '0) ? lang_code_low_byte_ff : lang_code_high_byte_ff) : mem_rd_b;

    // reply sequencer: length, type, then body bytes
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_len = len_ff;
        nxt_base = base_ff;
        nxt_is_lang = is_lang_ff;
        nxt_data = data_ff;
        nxt_stall = 1'b0;
        case (state_ff)
            HSDC_IDLE:
                if (desc_req_i)
                begin
                    nxt_cnt = '0;
                    nxt_state = HSDC_HEAD_LEN;
                    // a single language code, two bytes
                    nxt_is_lang = (desc_index_i == `HSDC_IDX_LANG);
                    case (desc_index_i)
                        `HSDC_IDX_LANG: nxt_len = `HSDC_LANG_BYTES;
                        `HSDC_IDX_SERIAL:
                        begin
                            nxt_len = clamp(AW'(serial_text_length_ff), SER_DEPTH);
                            nxt_base = '0;
                        end
                        `HSDC_IDX_MAKER:
                        begin
                            nxt_len = clamp(maker_text_length_ff, MAK_DEPTH);
                            nxt_base = AW'(SER_DEPTH);
                        end
                        default: nxt_len = '0; // index not offered
                    endcase
                    nxt_data = 8'(nxt_len + `HSDC_DESC_HEAD_LEN);
                    // zero length means no such string
                    if (nxt_len == '0)
                    begin
                        nxt_state = HSDC_IDLE;
                        nxt_stall = 1'b1;
                    end
                end
            HSDC_HEAD_LEN:
                if (desc_ready_i)
                begin
                    nxt_data = `HSDC_DESC_TYPE_STRING;
                    nxt_state = HSDC_HEAD_TYPE;
                end
            HSDC_HEAD_TYPE:
                if (desc_ready_i)
                begin
                    nxt_data = body_byte;
                    nxt_cnt = AW'(cnt_ff + 1'b1);
                    nxt_state = HSDC_BODY;
                end
            HSDC_BODY:
                if (desc_ready_i)
                begin
                    // stop after exactly len body bytes
                    if (cnt_ff == len_ff)
                        nxt_state = HSDC_IDLE;
                    else
                    begin
                        nxt_data = body_byte;
                        nxt_cnt = AW'(cnt_ff + 1'b1);
                    end
                end
            default: nxt_state = HSDC_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= HSDC_IDLE;
            cnt_ff <= '0;
            len_ff <= '0;
            base_ff <= '0;
            is_lang_ff <= 1'b0;
            data_ff <= 8'h00;
            stall_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            len_ff <= nxt_len;
            base_ff <= nxt_base;
            is_lang_ff <= nxt_is_lang;
            data_ff <= nxt_data;
            stall_ff <= nxt_stall;
        end
    end

    assign desc_valid_o = (state_ff != HSDC_IDLE);
    assign desc_busy_o = (state_ff != HSDC_IDLE);
    assign desc_data_o = data_ff;
    assign desc_last_o = (state_ff == HSDC_BODY) && (cnt_ff == len_ff);
    assign desc_stall_o = stall_ff;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    // reserved bits of tuning register reads stay zero
    reserved_tuning_config_read_zero_a: assert property (
        (ce_i && cfg_rd_i && cfg_addr_i == `HSDC_OFS_TUNE) |=> (cfg_rdata_o & 8'hE1) == 8'h00)
        else $error("reserved tuning bits read non-zero");
    // i2c load stores masked data
    tune_ee_load_a: assert property (
        (ce_i && ee_wr_i && !smb_wr_i && !smbus_mode_i && cfg_addr_i == `HSDC_OFS_TUNE)
        |=> tune_ff == ($past(cfg_wdata_i) & `HSDC_TUNE_WR_MASK))
        else $error("eeprom load of tuning register lost");
    // smbus host write replaces bits
    tune_smb_write_a: assert property (
        (ce_i && smb_wr_i && smbus_mode_i && cfg_addr_i == `HSDC_OFS_TUNE)
        |=> tune_cfg_o == ($past(cfg_wdata_i) & `HSDC_TUNE_WR_MASK))
        else $error("smbus write of tuning register lost");
    // language bytes locked without custom enable
    lang_locked_a: assert property (
        (ce_i && !custom_text_enable_i) |=> $stable(lang_code_low_byte_ff)
        && $stable(lang_code_high_byte_ff))
        else $error("language byte changed while locked");
    // index 0 reply is length 4, one code
    lang_reply_a: assert property (
        (ce_i && state_ff == HSDC_IDLE && desc_req_i && desc_index_i == `HSDC_IDX_LANG)
        |=> desc_valid_o && desc_data_o == 8'h04)
        else $error("language reply length wrong");
    // language body bytes in low, high order
    lang_bytes_a: assert property (
        (ce_i && state_ff == HSDC_HEAD_TYPE && is_lang_ff && desc_ready_i)
        |=> desc_data_o == lang_code_low_byte_ff ##0 ((!ce_i || !desc_ready_i)
        or (ce_i && desc_ready_i ##1 desc_data_o == lang_code_high_byte_ff && desc_last_o)))
        else $error("language bytes out of order");
    // empty maker string refused in one cycle
    maker_empty_a: assert property (
        (ce_i && state_ff == HSDC_IDLE && desc_req_i && desc_index_i == `HSDC_IDX_MAKER
        && maker_text_length_ff == '0) |=> desc_stall_o && !desc_valid_o)
        else $error("empty maker string not refused");
    // serial reply header carries length plus two
    serial_len_a: assert property (
        (ce_i && state_ff == HSDC_IDLE && desc_req_i && desc_index_i == `HSDC_IDX_SERIAL
        && serial_text_length_ff != '0 && int'(serial_text_length_ff) <= SER_DEPTH)
        |=> desc_data_o == 8'(serial_text_length_ff + 2'd2))
        else $error("serial reply length wrong");
    // length registers leave reset at their defaults
    len_reset_a: assert property (
        $rose(nrst_i) |-> serial_text_length_ff == 6'h14 && maker_text_length_ff == 7'h00)
        else $error("length register reset value wrong");

endmodule : hsdc_string_regs

// File: verif/hsdc_cfg_host.sv
`timescale 1ns/100ps

// configuration party: eeprom loader or smbus host, one byte at a time
module hsdc_cfg_host
(
    input wire logic ref_clk_i,
    output logic ee_wr_o,
    output logic smb_wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    // idle lines at time zero
    initial
    begin
        ee_wr_o = 1'b0;
        smb_wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'hFF;
        wdata_o = 8'h00;
    end

    // one write on the chosen bus; unless raw is set, tuning data gets bits 4:2 cleared and bit 1 set, lengths capped at 20h and 40h
    task automatic put(input logic smb, input logic [7:0] a, input logic [7:0] d,
                       input logic raw);
        logic [7:0] v;
        v = d;
        if (!raw && a == 8'h0A)
        begin
            v = (d & 8'hE3) | 8'h02;
        end
        if (!raw && a == 8'h22 && d > 8'h20)
        begin
            v = 8'h20;
        end
        if (!raw && a == 8'h23 && d > 8'h40)
        begin
            v = 8'h40;
        end
        @(negedge ref_clk_i);
        ee_wr_o = !smb;
        smb_wr_o = smb;
        addr_o = a;
        wdata_o = v;
        @(negedge ref_clk_i);
        ee_wr_o = 1'b0;
        smb_wr_o = 1'b0;
        // released lines show the inverse, never the old value
        addr_o = ~a;
        wdata_o = ~v;
    endtask : put

    // one read request, taken at the next rising edge
    task automatic get(input logic [7:0] a);
        @(negedge ref_clk_i);
        rd_o = 1'b1;
        addr_o = a;
        @(negedge ref_clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
    endtask : get
endmodule : hsdc_cfg_host

// File: verif/hsdc_string_regs_tb_top.sv
`timescale 1ns/100ps
`include "hsdc_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end

module hsdc_string_regs_tb_top;
    logic ref_clk_i = 1'b0; // bench clock
    logic nrst_i; // async reset, low active
    logic ce_i, smbus_mode_i, custom_text_enable_i;
    logic desc_req_i, desc_ready_i;
    logic [7:0] desc_index_i;
    logic ee_wr, smb_wr, cfg_rd; // host strobes
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata_o, tune_cfg_o, desc_data_o;
    logic desc_valid_o, desc_last_o, desc_stall_o, desc_busy_o;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 88318;
    int cycles = 0;
    bit rd_seen = 1'b0; // a read was taken last edge
    logic [7:0] reg_q[$]; // expected read bytes
    logic [9:0] desc_q[$]; // expected {stall, last, byte}
    logic [7:0] exp_r;
    logic [9:0] exp_d, got_d;
    logic [7:0] lang_lo, lang_hi;
    logic [7:0] ser_mem[32];
    logic [7:0] mak_mem[64];
    int ser_len, mak_len;

    // 25 MHz clock
    always #20 ref_clk_i = ~ref_clk_i;

    hsdc_string_regs i_hsdc_string_regs (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .smbus_mode_i(smbus_mode_i), .custom_text_enable_i(custom_text_enable_i),
        .ee_wr_i(ee_wr), .smb_wr_i(smb_wr), .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr),
        .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata_o), .tune_cfg_o(tune_cfg_o),
        .desc_req_i(desc_req_i), .desc_index_i(desc_index_i), .desc_ready_i(desc_ready_i),
        .desc_valid_o(desc_valid_o), .desc_data_o(desc_data_o), .desc_last_o(desc_last_o),
        .desc_stall_o(desc_stall_o), .desc_busy_o(desc_busy_o));

    hsdc_cfg_host i_hsdc_cfg_host (.ref_clk_i(ref_clk_i), .ee_wr_o(ee_wr), .smb_wr_o(smb_wr),
        .rd_o(cfg_rd), .addr_o(cfg_addr), .wdata_o(cfg_wdata));

    // verdict and end of run
    task automatic stop_test;
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // write on the bus of the current mode
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic raw);
        i_hsdc_cfg_host.put(smbus_mode_i, a, d, raw);
    endtask : put

    // read with its expected byte noted first
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        reg_q.push_back(e);
        i_hsdc_cfg_host.get(a);
    endtask : rchk

    // descriptor request; reply noted from the shadow, consumer stalls at random
    task automatic dreq(input logic [7:0] idx);
        logic [7:0] b[$];
        int k;
        if (idx == `HSDC_IDX_LANG)
            b = {lang_lo, lang_hi};
        else if (idx == `HSDC_IDX_SERIAL)
            for (k = 0; k < ser_len; k++) b.push_back(ser_mem[k]);
        else if (idx == `HSDC_IDX_MAKER)
            for (k = 0; k < mak_len; k++) b.push_back(mak_mem[k]);
        if (b.size() == 0)
            desc_q.push_back(10'h200);
        else
        begin
            desc_q.push_back({2'b00, 8'(b.size() + 2)});
            desc_q.push_back({2'b00, `HSDC_DESC_TYPE_STRING});
            foreach (b[i]) desc_q.push_back({1'b0, i == b.size() - 1, b[i]});
        end
        @(negedge ref_clk_i);
        ce_i = 1'b1;
        desc_req_i = 1'b1;
        desc_index_i = idx;
        @(negedge ref_clk_i);
        desc_req_i = 1'b0;
        desc_index_i = 8'($random(seed));
        for (k = 0; k < 1000 && (desc_busy_o !== 1'b0 || desc_q.size() > 0); k++)
        begin
            @(negedge ref_clk_i);
            ce_i = 1'($random(seed));
            desc_ready_i = 1'($random(seed));
        end
        `CHK(desc_q.size(), 0)
        ce_i = 1'b1;
    endtask : dreq

    // result watcher: reads one edge after being taken, bytes when consumed
    always @(posedge ref_clk_i)
    begin
        if (rd_seen)
        begin
            exp_r = reg_q.pop_front();
            `CHK(cfg_rdata_o, exp_r)
        end
        rd_seen = cfg_rd && ce_i;
        if (ce_i && (desc_stall_o || (desc_valid_o && desc_ready_i)))
        begin
            exp_d = desc_q.pop_front();
            got_d = desc_stall_o ? {1'b1, desc_valid_o, 8'h00} : {1'b0, desc_last_o, desc_data_o};
            `CHK(got_d, exp_d)
        end
    end

    // hang guard
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // main sequence
    initial
    begin
        nrst_i = 1'b0;
        ce_i = 1'b1;
        smbus_mode_i = 1'b0;
        custom_text_enable_i = 1'b0;
        desc_req_i = 1'b0;
        desc_index_i = 8'h00;
        desc_ready_i = 1'b1;
        lang_lo = 8'h09;
        lang_hi = 8'h04;
        ser_len = 20;
        mak_len = 0;
        repeat (8) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        nrst_i = 1'b1;
        // reset values and an unmapped offset
        rchk(`HSDC_OFS_TUNE, `HSDC_TUNE_RST);
        rchk(8'h20, 8'h09);
        rchk(8'h21, 8'h04);
        rchk(8'h22, 8'h14);
        rchk(8'h23, 8'h00);
        rchk(8'h10, 8'h00);
        // eeprom load with reserved bits set
        put(8'h0A, 8'hFF, 1'b1);
        `CHK(tune_cfg_o, 8'h1E)
        i_hsdc_cfg_host.put(1'b1, 8'h0A, 8'h02, 1'b0);
        rchk(8'h0A, 8'h1E);
        dreq(`HSDC_IDX_LANG);
        dreq(`HSDC_IDX_MAKER);
        dreq(8'h02);
        // language bytes locked, then opened
        put(8'h20, 8'h55, 1'b0);
        rchk(8'h20, 8'h09);
        custom_text_enable_i = 1'b1;
        lang_lo = 8'($random(seed));
        lang_hi = 8'($random(seed));
        put(8'h20, lang_lo, 1'b0);
        put(8'h21, lang_hi, 1'b0);
        rchk(8'h20, lang_lo);
        rchk(8'h21, lang_hi);
        // oversize lengths keep only their fields
        put(8'h22, 8'hFF, 1'b1);
        rchk(8'h22, 8'h3F);
        put(8'h23, 8'hFF, 1'b1);
        rchk(8'h23, 8'h7F);
        // smbus mode: eeprom ignored, host writes tuning
        smbus_mode_i = 1'b1;
        i_hsdc_cfg_host.put(1'b0, 8'h0A, 8'h02, 1'b0);
        rchk(8'h0A, 8'h1E);
        put(8'h0A, 8'hE1, 1'b1);
        rchk(8'h0A, 8'h00);
        put(8'h0A, 8'h02, 1'b0);
        `CHK(tune_cfg_o, 8'h02)
        // string stores and replies, random then maximum lengths
        for (int r = 0; r < 2; r++)
        begin
            smbus_mode_i = r[0];
            ser_len = r ? 32 : ($random(seed) & 31) + 1;
            mak_len = r ? 64 : ($random(seed) & 63) + 1;
            foreach (ser_mem[i])
            begin
                ser_mem[i] = 8'($random(seed));
                put(8'h30 + 8'(i), ser_mem[i], 1'b0);
            end
            foreach (mak_mem[i])
            begin
                mak_mem[i] = 8'($random(seed));
                put(8'h50 + 8'(i), mak_mem[i], 1'b0);
            end
            put(8'h22, 8'(ser_len), 1'b0);
            put(8'h23, 8'(mak_len), 1'b0);
            rchk(8'h22, 8'(ser_len));
            rchk(8'h4F, ser_mem[31]);
            rchk(8'h8F, mak_mem[63]);
            dreq(`HSDC_IDX_SERIAL);
            dreq(`HSDC_IDX_MAKER);
            dreq(`HSDC_IDX_LANG);
        end
        repeat (2) @(negedge ref_clk_i);
        stop_test();
    end
endmodule : hsdc_string_regs_tb_top
